// ---- src/tmac_map.svh ----
// Register map and timing constants of the fan-start adjustment interval block
`ifndef TMAC_MAP_SVH
`define TMAC_MAP_SVH
`define TMAC_ADDR_W 8
`define TMAC_OFS_INTERVAL 8'h37
`define TMAC_OFS_DYN_CTRL 8'h36
`define TMAC_OFS_LOCK 8'h40
`define TMAC_OFS_STATUS 8'h41
`define TMAC_RST_INTERVAL 8'h00
`define TMAC_RST_DYN_CTRL 8'h00
`define TMAC_F_R1_LSB 0
`define TMAC_F_L_LSB 3
`define TMAC_F_R2_LSB 6
`define TMAC_F_R2_MSB_BIT 0
`define TMAC_F_R1_EN_BIT 5
`define TMAC_F_L_EN_BIT 6
`define TMAC_F_R2_EN_BIT 7
`define TMAC_F_LOCK_BIT 1
`define TMAC_DEC_BASE 12'd8
`define TMAC_CNT_W 12
`endif

// ---- src/tmac_pkg.sv ----
// Types shared by the adjustment interval block
package tmac_pkg;
	typedef logic [2:0] tmac_code_t;
	typedef logic [11:0] tmac_count_t;
endpackage

// ---- src/tmac_interval.sv ----
// Adjustment interval register bank with per-channel wait timers
//
// Summary of operation
// - Bits 2:0 hold remote1 interval code
// - Bits 5:3 hold local interval code
// - Remote2 code MSB from dynamic control bit0
// - Decrease wait 8<<code, increase twice that
// - At most one adjustment per wait period
// - Writes ignored once lock bit set
// - Interval register resets to zero
// - Intervals act only when channel enabled
`include "tmac_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tmac_interval
	import tmac_pkg::*;
#(
	parameter int NCH = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic monitor_cycle_i,
	input wire logic [NCH-1:0] adj_dec_req_i,
	input wire logic [NCH-1:0] adj_inc_req_i,
	output logic [NCH-1:0] adj_dec_o,
	output logic [NCH-1:0] adj_inc_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers and bus

logic [7:0] interval_reg;
logic [7:0] dyn_ctrl_reg;
logic lock_reg;
logic ack_reg;
logic [31:0] rdata_reg;
logic [NCH-1:0] adj_dec_reg;
logic [NCH-1:0] adj_inc_reg;
wire logic req = avs_read_i | avs_write_i;
wire logic wr_stb = avs_write_i & ~ack_reg;
wire logic sel_int = avs_address_i == `TMAC_OFS_INTERVAL;
wire logic sel_dyn = avs_address_i == `TMAC_OFS_DYN_CTRL;
wire logic sel_lock = avs_address_i == `TMAC_OFS_LOCK;
wire logic sel_stat = avs_address_i == `TMAC_OFS_STATUS;
wire logic wr_int = wr_stb & sel_int & ~lock_reg;
wire logic wr_dyn = wr_stb & sel_dyn & ~lock_reg;
wire logic wr_lock = wr_stb & sel_lock & avs_writedata_i[`TMAC_F_LOCK_BIT];
wire logic [7:0] status_val = {2'h0, adj_inc_reg, adj_dec_reg};
wire logic [7:0] rd_mux = sel_int ? interval_reg :
	sel_dyn ? dyn_ctrl_reg :
	sel_lock ? {6'h00, lock_reg, 1'b0} :
	sel_stat ? status_val : 8'h00;

// One wait state: request taken, answer at the next edge
assign avs_waitrequest_o = req & ~ack_reg;
assign avs_readdata_o = rdata_reg;

always_ff @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		interval_reg <= `TMAC_RST_INTERVAL;
		dyn_ctrl_reg <= `TMAC_RST_DYN_CTRL;
		lock_reg <= 1'b0;
		ack_reg <= 1'b0;
		rdata_reg <= 32'h0000_0000;
	end else begin
		ack_reg <= req & ~ack_reg;
		if (wr_int) interval_reg <= avs_writedata_i[7:0];
		if (wr_dyn) dyn_ctrl_reg <= avs_writedata_i[7:0];
		if (wr_lock) lock_reg <= 1'b1; // Write-once, only reset clears
		if (avs_read_i & ~ack_reg) rdata_reg <= {24'h00_0000, rd_mux};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel codes and enables

tmac_code_t code [NCH];
logic [NCH-1:0] chan_en;
assign code[0] = interval_reg[`TMAC_F_R1_LSB +: 3];
assign code[1] = interval_reg[`TMAC_F_L_LSB +: 3];
assign code[2] = {dyn_ctrl_reg[`TMAC_F_R2_MSB_BIT], interval_reg[`TMAC_F_R2_LSB +: 2]};
assign chan_en = {dyn_ctrl_reg[`TMAC_F_R2_EN_BIT], dyn_ctrl_reg[`TMAC_F_L_EN_BIT],
	dyn_ctrl_reg[`TMAC_F_R1_EN_BIT]};

////////////////////////////////////////////////////////////////////////////////
// Wait timers, one per channel

// Requests come from the loop logic, which tracks the operating point
genvar g;
generate
	for (g = 0; g < NCH; g++) begin : g_ch
		// Each channel owns its state, so no variable has two writing processes
		tmac_count_t cnt_reg;
		logic dec_pulse_reg;
		logic inc_pulse_reg;
		wire tmac_count_t dec_wait = tmac_count_t'(`TMAC_DEC_BASE << code[g]);
		wire tmac_count_t inc_wait = tmac_count_t'(dec_wait << 1);
		wire logic dec_ok = cnt_reg >= dec_wait;
		wire logic inc_ok = cnt_reg >= inc_wait;
		wire logic do_dec = chan_en[g] & adj_dec_req_i[g] & dec_ok;
		wire logic do_inc = chan_en[g] & adj_inc_req_i[g] & inc_ok & ~do_dec;
		// Saturate at the longer wait, so the counter wraps only if a lower code leaves the count above it
		wire logic sat = cnt_reg == inc_wait;
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				cnt_reg <= '0;
				dec_pulse_reg <= 1'b0;
				inc_pulse_reg <= 1'b0;
			end else begin
				dec_pulse_reg <= do_dec;
				inc_pulse_reg <= do_inc;
				if (!chan_en[g] || do_dec || do_inc) cnt_reg <= '0;
				else if (monitor_cycle_i && !sat) cnt_reg <= cnt_reg + 12'h001;
			end
		end
		assign adj_dec_reg[g] = dec_pulse_reg;
		assign adj_inc_reg[g] = inc_pulse_reg;
	end
endgenerate

assign adj_dec_o = adj_dec_reg;
assign adj_inc_o = adj_inc_reg;

endmodule // tmac_interval
`default_nettype wire

// ---- sim/tmac_interval_checker.sv ----
// Concurrent checks on the adjustment grant outputs
`timescale 1ns/1ps
`default_nettype none
module tmac_interval_checker #(parameter int NCH = 3) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [NCH-1:0] adj_dec_req_i,
	input wire logic [NCH-1:0] adj_inc_req_i,
	input wire logic [NCH-1:0] adj_dec_o,
	input wire logic [NCH-1:0] adj_inc_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Shortest wait is 8 monitor pulses, so no grant for 7 clocks
	sequence s_idle(x); !x [*7]; endsequence
	a_dec_gap0: assert property (adj_dec_o[0] |=> s_idle(adj_dec_o[0]))
		else $error("dec grant 0 too soon");
	a_dec_gap2: assert property (adj_dec_o[2] |=> s_idle(adj_dec_o[2]))
		else $error("dec grant 2 too soon");
	a_inc_gap2: assert property (adj_inc_o[2] |=> !adj_inc_o[2] [*8])
		else $error("inc grant 2 too soon");
	a_never_both: assert property ((adj_dec_o & adj_inc_o) == '0)
		else $error("dec and inc together");
	a_dec_cause: assert property (adj_dec_o[0] |-> $past(adj_dec_req_i[0]))
		else $error("dec grant 0 unrequested");
	a_inc_cause: assert property (adj_inc_o[0] |-> $past(adj_inc_req_i[0]))
		else $error("inc grant 0 unrequested");
	a_no_request: assert property (!$past(adj_dec_req_i[1]) |-> !adj_dec_o[1])
		else $error("dec grant 1 unrequested");
	a_pulse_once: assert property (adj_dec_o[0] |=> !adj_dec_o[0])
		else $error("dec grant 0 held");
endmodule // tmac_interval_checker
bind tmac_interval tmac_interval_checker #(.NCH(NCH)) i_chk (.core_clk_i, .rst_i,
	.adj_dec_req_i, .adj_inc_req_i, .adj_dec_o, .adj_inc_o);
`default_nettype wire

// ---- sim/tmac_interval_bench.sv ----
// Self-checking bench for the adjustment interval block
`timescale 1ns/1ps
`default_nettype none
module tmac_interval_bench;
	logic core_clk_i = 0, rst_i = 1, rd = 0, wr = 0, mon = 0, wt;
	logic [7:0] ad = 0;
	logic [31:0] wd = 0, q, rdat;
	logic [2:0] dq = 0, iq = 0, dg, ig;
	int num_errors = 0, tests_run = 0, t = 0, g = 0;
	logic [23:0] row [4] = '{24'h375a5a, 24'h362121, 24'h00ff00, 24'h37a0a0};
	always #12.5 core_clk_i = ~core_clk_i;
	tmac_interval i_dut (.core_clk_i, .rst_i, .avs_address_i(ad), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wt), .monitor_cycle_i(mon), .adj_dec_req_i(dq),
		.adj_inc_req_i(iq), .adj_dec_o(dg), .adj_inc_o(ig));
	////////////////////////////////////////
	task end_of_test;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("FAIL %s exp %h seen %h", nm, e, s);
		end
	endtask
	// Request held until waitrequest seen low at an edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		ad <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		repeat (20) begin
			@(posedge core_clk_i);
			if (wt === 1'b0) break;
		end
		if (wt !== 1'b0) begin
			num_errors++;
			end_of_test;
		end
		q = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge core_clk_i);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_i <= 0;
		@(posedge core_clk_i);
		bus(0, 8'h37, 0);
		chk("reset", q, 0);
		foreach (row[i]) begin
			bus(1, row[i][23:16], {24'h0, row[i][15:8]});
			bus(0, row[i][23:16], 0);
			chk("reg", q, {24'h0, row[i][7:0]});
		end
		dq <= 3'b011;
		mon <= 1;
		repeat (60) begin
			@(posedge core_clk_i);
			t++;
			if (dg[0] === 1'b1) begin
				if (g++ > 0) chk("gap", {31'h0, t inside {8, 9}}, 1);
				t = 0;
			end
			chk("off", {29'h0, dg[1], ig[1:0]}, 0);
		end
		chk("grants", {31'h0, g > 3}, 1);
		dq <= 3'b000;
		iq <= 3'b011;
		t = 0;
		g = 0;
		repeat (80) begin
			@(posedge core_clk_i);
			t++;
			if (ig[0] === 1'b1) begin
				if (g++ > 0) chk("igap", {31'h0, t inside {16, 17}}, 1);
				t = 0;
			end
			chk("ioff", {30'h0, dg[0], ig[1]}, 0);
		end
		chk("igrants", {31'h0, g > 2}, 1);
		iq <= 3'b000;
		mon <= 0;
		bus(1, 8'h40, 32'h2);
		bus(1, 8'h37, 32'hff);
		bus(0, 8'h37, 0);
		chk("lock", q, 32'ha0);
		rst_i <= 1;
		repeat (2) @(posedge core_clk_i);
		rst_i <= 0;
		@(posedge core_clk_i);
		bus(0, 8'h37, 0);
		chk("rereset", q, 0);
		bus(1, 8'h37, 32'h12);
		bus(0, 8'h37, 0);
		chk("unlock", q, 32'h12);
		end_of_test;
	end
endmodule // tmac_interval_bench
`default_nettype wire
